//--- rtl/scan_timing_buffer_ctrl.sv
module scan_timing_buffer_ctrl
    import scan_timing_pkg::*;
#(
    parameter int CYCLE_W = 8
)
(
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    input  wire reg_req_t            i_req,
    input  wire logic                i_gcall_reset,
    input  wire logic                i_auto_seq_en,
    input  wire logic                i_seq_error,
    input  wire logic                i_hs_tick,
    input  wire logic                i_lp_tick,
    input  wire sample_t             i_sample,
    output logic [DATA_W-1:0]        o_rdata,
    output logic                     o_rd_valid,
    output logic                     o_busy_rdy,
    output logic                     o_conv_start,
    output logic                     o_lp_conversion_clock_source,
    output logic [POLICY_W-1:0]      o_capture_policy,
    output logic [LAYOUT_W-1:0]      o_word_layout,
    output logic [WORD_W-1:0]        o_buffer_word
);

    if (CYCLE_W != DATA_W)
    begin : g_bad_cycle_width
        $error("scan_timing_buffer_ctrl: CYCLE_W must equal register width");
    end

    // ==========================================================
    // Write decode
    logic wr_launch;
    logic wr_halt;
    logic wr_clk_src;
    logic wr_cycle;
    logic wr_layout;
    logic wr_policy;

    always_comb
    begin
        wr_launch  = i_req.wr && i_req.addr == OFF_SCAN_LAUNCH && i_req.wdata[LAUNCH_BIT];
        wr_halt    = i_req.wr && i_req.addr == OFF_SCAN_HALT && i_req.wdata[HALT_BIT];
        wr_clk_src = i_req.wr && i_req.addr == OFF_CLK_SOURCE;
        wr_cycle   = i_req.wr && i_req.addr == OFF_CYCLE_LENGTH;
        wr_layout  = i_req.wr && i_req.addr == OFF_WORD_LAYOUT;
        wr_policy  = i_req.wr && i_req.addr == OFF_CAPTURE_POL;
    end

    // ==========================================================
    // Configuration registers
    logic                clk_src_q;
    logic                clk_src_d;
    logic [CYCLE_W-1:0]  cycle_q;
    logic [CYCLE_W-1:0]  cycle_d;
    logic [LAYOUT_W-1:0] layout_q;
    logic [LAYOUT_W-1:0] layout_d;
    logic [POLICY_W-1:0] policy_q;
    logic [POLICY_W-1:0] policy_d;

    always_comb
    begin
        clk_src_d = clk_src_q;
        cycle_d   = cycle_q;
        layout_d  = layout_q;
        policy_d  = policy_q;
        if (wr_clk_src)
        begin
            clk_src_d = i_req.wdata[CLK_SRC_BIT];
        end
        if (wr_cycle)
        begin
            cycle_d = i_req.wdata[CYCLE_W-1:0];
        end
        if (wr_layout)
        begin
            layout_d = i_req.wdata[LAYOUT_W-1:0];
        end
        if (wr_policy)
        begin
            // Reserved codes are stored as written; the buffer owns their effect
            policy_d = i_req.wdata[POLICY_W-1:0];
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            clk_src_q <= RST_CLK_SRC;
            cycle_q   <= RST_CYCLE;
            layout_q  <= RST_LAYOUT;
            policy_q  <= RST_POLICY;
        end
        else
        begin
            clk_src_q <= clk_src_d;
            cycle_q   <= cycle_d;
            layout_q  <= layout_d;
            policy_q  <= policy_d;
        end
    end

    assign o_lp_conversion_clock_source     = clk_src_q;
    assign o_capture_policy = policy_q;
    assign o_word_layout    = layout_q;

    // ==========================================================
    // Scan sequencer
    scan_state_t state_q;
    scan_state_t state_d;
    logic        busy_d;
    logic        start_d;
    logic        cycle_done;

    always_comb
    begin
        state_d = state_q;
        busy_d  = o_busy_rdy;
        start_d = 1'b0;
        case (state_q)
            SCAN_IDLE:
            begin
                if (wr_launch)
                begin
                    state_d = SCAN_RUN;
                    busy_d  = 1'b1;
                    start_d = 1'b1;
                end
            end
            SCAN_RUN:
            begin
                if (wr_halt)
                begin
                    state_d = SCAN_IDLE;
                    busy_d  = 1'b0;
                end
                else if (wr_launch || cycle_done)
                begin
                    // A repeated launch restarts the sequence from its first conversion
                    start_d = 1'b1;
                end
            end
            default:
            begin
                state_d = SCAN_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_q      <= SCAN_IDLE;
            o_busy_rdy   <= 1'b0;
            o_conv_start <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            o_busy_rdy   <= busy_d;
            o_conv_start <= start_d;
        end
    end

    scan_cycle_timer #(
        .CNT_W (CYCLE_W)
    ) scan_cycle_timer_inst (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_run     (state_q == SCAN_RUN),
        .i_restart (o_conv_start),
        .i_lp_sel  (clk_src_q),
        .i_count   (cycle_q),
        .i_hs_tick (i_hs_tick),
        .i_lp_tick (i_lp_tick),
        .o_done    (cycle_done)
    );

    // ==========================================================
    // Scan state report
    logic               err_q;
    logic               err_d;
    logic [FAULT_W-1:0] fault_q;
    logic [FAULT_W-1:0] fault_d;
    logic               state_clr;

    always_comb
    begin
        state_clr = i_gcall_reset || wr_launch;
        // An error arriving with the clear survives it
        err_d     = i_seq_error || (err_q && !state_clr);
        if ((state_clr && !i_seq_error) || !i_auto_seq_en)
        begin
            fault_d = FAULT_OFF;
        end
        else
        begin
            fault_d = err_d ? FAULT_ERR : FAULT_OK;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            err_q   <= 1'b0;
            fault_q <= FAULT_OFF;
        end
        else
        begin
            err_q   <= err_d;
            fault_q <= fault_d;
        end
    end

    // ==========================================================
    // Register read port, answer one cycle after the request
    logic [DATA_W-1:0] rdata_d;

    always_comb
    begin
        rdata_d = '0;
        if (i_req.rd)
        begin
            case (i_req.addr)
                OFF_SCAN_STATE:   rdata_d[FAULT_LSB +: FAULT_W] = fault_q;
                OFF_CLK_SOURCE:   rdata_d[CLK_SRC_BIT]          = clk_src_q;
                OFF_CYCLE_LENGTH: rdata_d[CYCLE_W-1:0]          = cycle_q;
                OFF_WORD_LAYOUT:  rdata_d[LAYOUT_W-1:0]         = layout_q;
                OFF_CAPTURE_POL:  rdata_d[POLICY_W-1:0]         = policy_q;
                default:          rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_rdata    <= '0;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rdata    <= rdata_d;
            o_rd_valid <= i_req.rd;
        end
    end

    // ==========================================================
    // Buffer word packing
    logic [WORD_W-1:0] word_d;

    always_comb
    begin
        case (layout_q)
            LAY_CHAN: word_d = {i_sample.result, i_sample.chan, 1'b0};
            LAY_FULL: word_d = {i_sample.result, i_sample.chan, i_sample.valid};
            default:  word_d = {i_sample.result, {(WORD_W-RESULT_W){1'b0}}};
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_buffer_word <= '0;
        end
        else
        begin
            o_buffer_word <= word_d;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    chk_launch_busy: assert property (
        (state_q == SCAN_IDLE && wr_launch) |=> o_busy_rdy && o_conv_start)
        else $error("launch did not raise activity pin");
    chk_halt_stops: assert property (
        wr_halt |=> !o_busy_rdy && !o_conv_start ##1 !o_busy_rdy)
        else $error("halt did not stop the scan");
    chk_state_clear: assert property (
        (wr_launch && !i_seq_error) |=> fault_q == FAULT_OFF)
        else $error("scan state not cleared on launch");
    chk_fault_code: assert property (
        fault_q != FAULT_UNUS && ($past(i_auto_seq_en) || fault_q == FAULT_OFF))
        else $error("bad scan fault code");
    chk_error_sticky: assert property (
        (i_seq_error && i_auto_seq_en) ##1 (i_auto_seq_en && !state_clr) |=> fault_q == FAULT_ERR)
        else $error("error state lost");
    chk_clk_source: assert property (
        wr_clk_src |=> o_lp_conversion_clock_source == $past(i_req.wdata[CLK_SRC_BIT]))
        else $error("clock source not updated");
    chk_policy_hold: assert property (
        !wr_policy |=> $stable(o_capture_policy))
        else $error("capture policy changed without a write");
    chk_layout_pad: assert property (
        (layout_q == LAY_PAD || layout_q == LAY_PAD_B) |=> o_buffer_word[WORD_W-RESULT_W-1:0] == '0)
        else $error("padded layout carries nonzero low bits");
    chk_pulse_reads: assert property (
        (i_req.rd && (i_req.addr == OFF_SCAN_LAUNCH || i_req.addr == OFF_SCAN_HALT))
        |=> o_rd_valid && o_rdata == '0)
        else $error("launch or halt reads nonzero");
    chk_upper_zero: assert property (
        (i_req.rd && i_req.addr == OFF_CLK_SOURCE) |=> o_rdata[DATA_W-1:1] == '0)
        else $error("clock source upper bits nonzero");
    // A done pulse may trail a halt by one cycle; the pin is already low then
    chk_run_cycles: assert property (
        cycle_done |-> (state_q == SCAN_RUN || !o_busy_rdy) ##1 (o_conv_start || !o_busy_rdy))
        else $error("cycle end did not start next conversion");

    cov_launch_halt: cover property (wr_launch ##[1:50] wr_halt);
    cov_cycle_end:   cover property (o_conv_start ##[1:1000] cycle_done);
    cov_fault_err:   cover property (fault_q == FAULT_ERR);
    cov_lp_floor:    cover property (clk_src_q && cycle_q <= MIN_CYCLE_LP && cycle_done);

endmodule

//--- rtl/scan_timing_pkg.sv
package scan_timing_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_SCAN_STATE   = 8'h04;
    localparam logic [7:0] OFF_CLK_SOURCE   = 8'h18;
    localparam logic [7:0] OFF_CYCLE_LENGTH = 8'h19;
    localparam logic [7:0] OFF_SCAN_LAUNCH  = 8'h1E;
    localparam logic [7:0] OFF_SCAN_HALT    = 8'h1F;
    localparam logic [7:0] OFF_WORD_LAYOUT  = 8'h28;
    localparam logic [7:0] OFF_CAPTURE_POL  = 8'h2C;

    // ==========================================================
    // Field positions
    localparam int LAUNCH_BIT    = 0;
    localparam int HALT_BIT      = 0;
    localparam int CLK_SRC_BIT   = 0;
    localparam int FAULT_LSB     = 1;
    localparam int POLICY_W      = 3;
    localparam int LAYOUT_W      = 2;
    localparam int FAULT_W       = 2;
    localparam int DATA_W        = 8;
    localparam int RESULT_W      = 12;
    localparam int CHAN_W        = 3;
    localparam int WORD_W        = 16;

    // ==========================================================
    // Reset values
    localparam logic                RST_CLK_SRC = 1'h0;
    localparam logic [DATA_W-1:0]   RST_CYCLE   = 8'h00;
    localparam logic [LAYOUT_W-1:0] RST_LAYOUT  = 2'h0;
    localparam logic [POLICY_W-1:0] RST_POLICY  = 3'h1;

    // ==========================================================
    // Cycle length floors per oscillator
    localparam logic [DATA_W-1:0] MIN_CYCLE_HS = 8'h15;
    localparam logic [DATA_W-1:0] MIN_CYCLE_LP = 8'h12;

    // ==========================================================
    // Codes
    localparam logic [FAULT_W-1:0]  FAULT_OFF  = 2'h0;
    localparam logic [FAULT_W-1:0]  FAULT_OK   = 2'h1;
    localparam logic [FAULT_W-1:0]  FAULT_UNUS = 2'h2;
    localparam logic [FAULT_W-1:0]  FAULT_ERR  = 2'h3;
    localparam logic [POLICY_W-1:0] POL_STOP   = 3'h0;
    localparam logic [POLICY_W-1:0] POL_START  = 3'h1;
    localparam logic [POLICY_W-1:0] POL_PRE    = 3'h4;
    localparam logic [POLICY_W-1:0] POL_POST   = 3'h6;
    localparam logic [LAYOUT_W-1:0] LAY_PAD    = 2'h0;
    localparam logic [LAYOUT_W-1:0] LAY_CHAN   = 2'h1;
    localparam logic [LAYOUT_W-1:0] LAY_FULL   = 2'h2;
    localparam logic [LAYOUT_W-1:0] LAY_PAD_B  = 2'h3;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN  = 2'b10
    } scan_state_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [7:0]        addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [RESULT_W-1:0] result;
        logic [CHAN_W-1:0]   chan;
        logic                valid;
    } sample_t;

endpackage

//--- rtl/scan_cycle_timer.sv
module scan_cycle_timer
    import scan_timing_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_run,
    input  wire logic             i_restart,
    input  wire logic             i_lp_sel,
    input  wire logic [CNT_W-1:0] i_count,
    input  wire logic             i_hs_tick,
    input  wire logic             i_lp_tick,
    output logic                  o_done
);

    if (CNT_W < 5 || CNT_W > DATA_W)
    begin : g_bad_width
        $error("scan_cycle_timer: CNT_W must be 5 to 8");
    end

    logic [CNT_W-1:0] floor_cnt;
    logic [CNT_W-1:0] eff_cnt;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             done_d;
    logic             tick;

    // ==========================================================
    // Effective length, re-evaluated whenever the source changes
    always_comb
    begin
        floor_cnt = i_lp_sel ? CNT_W'(MIN_CYCLE_LP) : CNT_W'(MIN_CYCLE_HS);
        eff_cnt   = (i_count <= floor_cnt) ? floor_cnt : i_count;
        tick      = i_lp_sel ? i_lp_tick : i_hs_tick;
    end

    // ==========================================================
    // Oscillator clock counter
    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (!i_run || i_restart)
        begin
            cnt_d = '0;
        end
        else if (tick)
        begin
            if (cnt_q == eff_cnt - CNT_W'(1))
            begin
                cnt_d  = '0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            cnt_q  <= '0;
            o_done <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            o_done <= done_d;
        end
    end

    chk_cycle_floor: assert property (@(posedge i_mclk) disable iff (i_rst)
        eff_cnt >= (i_lp_sel ? CNT_W'(MIN_CYCLE_LP) : CNT_W'(MIN_CYCLE_HS)))
        else $error("cycle length below oscillator floor");

    chk_done_at_end: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_done |-> $past(cnt_q) == $past(eff_cnt) - CNT_W'(1))
        else $error("cycle ended before programmed count");

endmodule

//--- verif/osc_tick_model.sv
module osc_tick_model
#(
    parameter int HS_DIV = 3,
    parameter int LP_DIV = 5
)
(
    input  wire logic i_mclk,
    input  wire logic i_rst,
    output logic      o_hs_tick,
    output logic      o_lp_tick
);
    timeunit 1ns;
    timeprecision 1ps;

    int hs_q;
    int lp_q;

    // ==========================================================
    // Free-running oscillators
    // Unequal rates, so counting the wrong source shows up as a wrong length.
    // Both dividers stay above 1: a tick never lands in two adjacent cycles.
    always @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            hs_q <= 0;
            lp_q <= 0;
            o_hs_tick <= 1'b0;
            o_lp_tick <= 1'b0;
        end
        else
        begin
            hs_q <= (hs_q == HS_DIV - 1) ? 0 : hs_q + 1;
            lp_q <= (lp_q == LP_DIV - 1) ? 0 : lp_q + 1;
            o_hs_tick <= (hs_q == HS_DIV - 1);
            o_lp_tick <= (lp_q == LP_DIV - 1);
        end
    end
endmodule

//--- verif/tb_scan_timing_buffer_ctrl.sv
module tb_scan_timing_buffer_ctrl
    import scan_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                mclk;
    logic                rst;
    reg_req_t            req;
    logic                gcall;
    logic                auto_en;
    logic                seq_err;
    logic                hs_tick;
    logic                lp_tick;
    sample_t             smp;
    logic [DATA_W-1:0]   rdata;
    logic                rd_valid;
    logic                busy;
    logic                conv_start;
    logic                lp_sel;
    logic [POLICY_W-1:0] policy;
    logic [LAYOUT_W-1:0] layout;
    logic [WORD_W-1:0]   bword;
    int                  err_count;
    int                  n_compared;
    int                  n;
    logic [7:0]          fl;
    logic [7:0]          ex;

    logic [7:0] ra [7] = '{8'h18, 8'h19, 8'h28, 8'h2C, 8'h1E, 8'h1F, 8'h05};
    logic [7:0] rz [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] wd [7] = '{8'hFF, 8'hAB, 8'hFF, 8'hFF, 8'hFE, 8'hFE, 8'hFF};
    logic [7:0] rx [7] = '{8'h01, 8'hAB, 8'h03, 8'h07, 8'h00, 8'h00, 8'h00};
    logic [2:0] pc [4] = '{POL_STOP, POL_START, POL_PRE, POL_POST};
    logic [7:0] ci [6] = '{8'h00, 8'h15, 8'h16, 8'h0A, 8'h12, 8'h13};
    logic       cl [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    scan_timing_buffer_ctrl #(.CYCLE_W(8)) scan_timing_buffer_ctrl_inst (
        .i_mclk(mclk), .i_rst(rst), .i_req(req), .i_gcall_reset(gcall),
        .i_auto_seq_en(auto_en), .i_seq_error(seq_err), .i_hs_tick(hs_tick),
        .i_lp_tick(lp_tick), .i_sample(smp), .o_rdata(rdata), .o_rd_valid(rd_valid),
        .o_busy_rdy(busy), .o_conv_start(conv_start), .o_lp_conversion_clock_source(lp_sel),
        .o_capture_policy(policy), .o_word_layout(layout), .o_buffer_word(bword));

    osc_tick_model #(.HS_DIV(3), .LP_DIV(5)) osc_tick_model_inst (
        .i_mclk(mclk), .i_rst(rst), .o_hs_tick(hs_tick), .o_lp_tick(lp_tick));

    // ==========================================================
    // Tasks
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask

    // Read data and its valid flag are judged together in the answer cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge mclk);
        req.rd = 1'b0;
        chk({7'h00, rd_valid, rdata}, {8'h01, exp});
    endtask

    // Counts selected ticks from one conversion start to the next
    task automatic measure(input logic lp, output int cnt);
        int t;
        cnt = 0;
        t = 0;
        while (conv_start !== 1'b1 && t < 50)
        begin
            @(negedge mclk);
            t++;
        end
        @(negedge mclk);
        t = 0;
        while (conv_start !== 1'b1 && t < 3000)
        begin
            if ((lp ? lp_tick : hs_tick) === 1'b1)
                cnt++;
            @(negedge mclk);
            t++;
        end
    endtask

    task automatic pulse_err;
        @(negedge mclk);
        seq_err = 1'b1;
        @(negedge mclk);
        seq_err = 1'b0;
    endtask

    // ==========================================================
    // Clock, watchdog
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Tests need about a thousand cycles; this 25000-cycle limit is well beyond that
    initial
    begin
        #200000;
        err_count++;
        report_and_stop;
    end

    // ==========================================================
    // Tests
    initial
    begin
        rst = 1'b1;
        req = '0;
        gcall = 1'b0;
        auto_en = 1'b0;
        seq_err = 1'b0;
        smp = '{result: 12'hA5C, chan: 3'h5, valid: 1'b1};
        err_count = 0;
        n_compared = 0;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        chk({9'h000, busy, lp_sel, layout, policy}, 16'h0001);
        rd(OFF_SCAN_STATE, 8'h00);
        for (int i = 0; i < 7; i++)
            rd(ra[i], rz[i]);
        for (int i = 0; i < 7; i++)
        begin
            wr(ra[i], wd[i]);
            rd(ra[i], rx[i]);
        end
        chk({9'h000, busy, lp_sel, layout, policy}, 16'h003F);
        $display("test registers done");

        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_CAPTURE_POL, {5'h00, pc[i]});
            chk({13'h0000, policy}, {13'h0000, pc[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_WORD_LAYOUT, 8'(i));
            // Packed word follows the layout register one cycle later
            @(negedge mclk);
            ex = 8'(i);
            if (ex == 8'h01)
                chk(bword, {smp.result, smp.chan, 1'b0});
            else if (ex == 8'h02)
                chk(bword, {smp.result, smp.chan, smp.valid});
            else
                chk(bword, {smp.result, 4'h0});
        end
        $display("test policy and layout done");

        for (int i = 0; i < 6; i++)
        begin
            wr(OFF_CLK_SOURCE, {7'h00, cl[i]});
            chk({15'h0000, lp_sel}, {15'h0000, cl[i]});
            wr(OFF_CYCLE_LENGTH, ci[i]);
            wr(OFF_SCAN_LAUNCH, 8'h01);
            chk({14'h0000, busy, conv_start}, 16'h0003);
            measure(cl[i], n);
            fl = cl[i] ? MIN_CYCLE_LP : MIN_CYCLE_HS;
            ex = (ci[i] <= fl) ? fl : ci[i];
            chk(16'(n), {8'h00, ex});
        end
        $display("test cycle length done");

        wr(OFF_SCAN_HALT, 8'h01);
        chk({15'h0000, busy}, 16'h0000);
        n = 0;
        repeat (300)
        begin
            @(negedge mclk);
            if (conv_start === 1'b1)
                n++;
        end
        chk(16'(n), 16'h0000);
        rd(OFF_SCAN_STATE, 8'h00);
        wr(OFF_SCAN_HALT, 8'h01);
        chk({15'h0000, busy}, 16'h0000);
        $display("test halt done");

        auto_en = 1'b1;
        rd(OFF_SCAN_STATE, 8'h02);
        pulse_err;
        rd(OFF_SCAN_STATE, 8'h06);
        @(negedge mclk);
        gcall = 1'b1;
        @(negedge mclk);
        gcall = 1'b0;
        rd(OFF_SCAN_STATE, 8'h02);
        pulse_err;
        wr(OFF_SCAN_LAUNCH, 8'h01);
        rd(OFF_SCAN_STATE, 8'h02);
        pulse_err;
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk({9'h000, busy, lp_sel, layout, policy}, 16'h0001);
        rd(OFF_SCAN_STATE, 8'h02);
        pulse_err;
        auto_en = 1'b0;
        rd(OFF_SCAN_STATE, 8'h00);
        $display("test scan state done");
        report_and_stop;
    end
endmodule
